// File: hw/tlb_defs.svh
// Offsets, field positions and reset values of the lookup block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef TLB_DEFS_SVH
`define TLB_DEFS_SVH
// Register byte offsets
`define TLB_OFS_STATUS  8'h00
`define TLB_OFS_KEY     8'h04
`define TLB_OFS_INDEX   8'h08
`define TLB_OFS_RANDOM  8'h0C
`define TLB_OFS_VPN2    8'h10
`define TLB_OFS_MASK    8'h14
`define TLB_OFS_LO0     8'h18
`define TLB_OFS_LO1     8'h1C
`define TLB_OFS_CMD     8'h20
`define TLB_OFS_ISTAT   8'h24
`define TLB_OFS_IMASK   8'h28
// Status field positions
`define TLB_ST_PRIV_LO  0
`define TLB_ST_EXL      2
`define TLB_ST_ERL      3
`define TLB_ST_UX       4
`define TLB_ST_SX       5
`define TLB_ST_KX       6
`define TLB_ST_CU3      7
// Command bits
`define TLB_CMD_WIDX    0
`define TLB_CMD_WRND    1
// Interrupt status bits
`define TLB_IRQ_MISS    0
`define TLB_IRQ_AERR    1
// Reset values
`define TLB_RST_PRIV    2'h0
`define TLB_RST_EXL     1'b0
`define TLB_RST_ERL     1'b1
// Page geometry
`define TLB_OFS_BITS    12
`define TLB_VPN2_LO     13
`define TLB_VA_BITS     40
`endif

// File: hw/tlb_lookup.sv
// Translation buffer with mode, instruction level and width decode.
// Assumes the pipeline drives lookups on the same clock.
//
// Behaviour
// - Fully associative, 48 entries, each an even/odd pair: 96 pages.
// - All entries compared in parallel against address plus current tag.
// - Page sizes 4 KB to 16 MB in steps of four.
// - Hit: physical page from entry joined with untouched offset bits.
// - No match on a mapped address raises a miss exception.
// - Entries written by software index or by random replacement.
// - Privilege 10 user, 01 supervisor; 00, 11 or any level bit kernel.
// - Exception sets exception level, error sets error level.
// - Interrupts blocked while either level bit is set.
// - Clearing both level bits returns at once to privilege field mode.
// - User: levels one, two; three if wide bit; four if coproc bit.
// - Supervisor: one, two, four, three if wide; kernel: all levels.
// - Address width 64 when the current mode's wide bit is set.
// - Two unmapped kernel segments bypass the buffer, never miss.
// - Match needs equal page number and global bit or equal tag.
// - Address tag is 8 bits from the translation key register.
`include "tlb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup #(
  parameter int ENTRIES = 48
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  // Pipeline lookup
  input  wire logic        lookup_valid,
  input  wire logic [63:0] lookup_vaddr,
  output logic             result_valid,
  output logic             result_hit,
  output logic             result_miss,
  output logic             result_addr_err,
  output logic [31:0]      result_paddr,
  // Pipeline exception events
  input  wire logic        exception_take,
  input  wire logic        error_take,
  // Mode decode
  output tlb_pkg::tlb_mode_t mode,
  output logic [3:0]       isa_levels,
  output logic             wide_addr,
  output logic             interrupts_blocked
);
  import tlb_pkg::*;

  // Index and random counter are six bits wide
  if (ENTRIES < 2 || ENTRIES > 64)
  begin
    $error("ENTRIES must be 2..64");
  end

  localparam logic [5:0] LAST = 6'(ENTRIES - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tlb_entry_t [ENTRIES-1:0] ent;
    logic [1:0]  privilege_field;
    logic        exception_level_bit;
    logic        error_level_bit;
    logic        user_wide_addr_bit;
    logic        supervisor_wide_addr_bit;
    logic        kernel_wide_addr_bit;
    logic        coproc_three_usable_bit;
    logic [7:0]  address_space_tag;
    logic [5:0]  index;
    logic [5:0]  random;
    tlb_entry_t  stage;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        rd_pend;
    logic [31:0] rdata;
    logic        r_valid;
    logic        r_hit;
    logic        r_miss;
    logic        r_aerr;
    logic [31:0] r_paddr;
  } tlb_state_t;

  tlb_state_t st;
  tlb_state_t next_st;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Number of set mask bits; each size step adds two
  function automatic logic [4:0] mask_bits(input logic [11:0] m);
    logic [4:0] n;
    n = 5'h0;
    for (int b = 0; b < 12; b++)
      n = n + 5'(m[b]);
    return n;
  endfunction

  // Page number compare ignoring masked bits, tag or global
  function automatic logic entry_match(input tlb_entry_t e,
                                       input logic [26:0] virtual_page_number,
                                       input logic [7:0] tag);
    logic [26:0] care;
    care = ~{15'h0, e.mask};
    return (((e.vpn2 ^ virtual_page_number) & care) == 27'h0) &&
           (e.global_bit || e.tag == tag);
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Level bits force kernel without touching the privilege field
  always_comb
  begin
    if (st.exception_level_bit || st.error_level_bit ||
        st.privilege_field == 2'b00 || st.privilege_field == 2'b11)
      mode = TLB_MODE_KERNEL;
    else if (st.privilege_field == 2'b10)
      mode = TLB_MODE_USER;
    else
      mode = TLB_MODE_SUPER;
  end

  // Instruction levels: bit 0 first level .. bit 3 fourth level
  always_comb
  begin
    unique case (mode)
      TLB_MODE_USER:
      begin
        isa_levels = {st.coproc_three_usable_bit,
                      st.user_wide_addr_bit, 2'b11};
        wide_addr  = st.user_wide_addr_bit;
      end
      TLB_MODE_SUPER:
      begin
        isa_levels = {1'b1, st.supervisor_wide_addr_bit, 2'b11};
        wide_addr  = st.supervisor_wide_addr_bit;
      end
      default:
      begin
        isa_levels = 4'hF;
        wide_addr  = st.kernel_wide_addr_bit;
      end
    endcase
  end

  assign interrupts_blocked = st.exception_level_bit |
                              st.error_level_bit;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] hit_vec;
  logic               any_hit;
  logic               odd_sel;
  logic [19:0]        hit_pfn;
  logic               hit_v;
  logic [24:0]        off_mask;
  logic [31:0]        mapped_pa;
  logic               unmapped;
  logic               aerr;
  tlb_entry_t         hit_ent;

  // Every entry compared at once; the first hit wins
  always_comb
  begin
    hit_ent = '0;
    for (int i = 0; i < ENTRIES; i++)
      hit_vec[i] = entry_match(st.ent[i], lookup_vaddr[39:13],
                               st.address_space_tag);
    for (int i = ENTRIES - 1; i >= 0; i--)
      if (hit_vec[i])
        hit_ent = st.ent[i];
  end

  // Pair select bit moves up two per size step
  always_comb
  begin
    odd_sel  = lookup_vaddr[5'(`TLB_OFS_BITS) + mask_bits(hit_ent.mask)];
    hit_pfn  = odd_sel ? hit_ent.pfn1 : hit_ent.pfn0;
    hit_v    = odd_sel ? hit_ent.v1 : hit_ent.v0;
    off_mask = {hit_ent.mask, 13'h1FFF} >> 1;
    mapped_pa = ({hit_pfn, 12'h000} & ~{7'h0, off_mask}) |
                (lookup_vaddr[31:0] & {7'h0, off_mask});
  end

  // An invalid half counts as a miss so software refills it
  assign any_hit = (|hit_vec) && hit_v;

  // Unmapped kernel windows at the top of the sign-extended space
  assign unmapped = (&lookup_vaddr[63:31]) &&
                    !lookup_vaddr[30];

  // Narrow mode needs a sign-extended address; user stays low
  assign aerr = (!wide_addr &&
                 lookup_vaddr[63:32] != {32{lookup_vaddr[31]}}) ||
                (wide_addr && mode != TLB_MODE_KERNEL &&
                 lookup_vaddr[63:40] != 24'h0) ||
                (mode == TLB_MODE_USER && lookup_vaddr[31] &&
                 !wide_addr) ||
                (mode != TLB_MODE_KERNEL && unmapped);

  // ----------------------------------------------------------------
  // Register bus and next state
  // ----------------------------------------------------------------
  logic       wr_en;
  logic [1:0] cmd;
  logic [1:0] ev;
  logic [5:0] wslot;
  logic       do_wr;

  always_comb
  begin
    next_st = st;
    wr_en   = write && !read;
    cmd     = (wr_en && address == `TLB_OFS_CMD) ? writedata[1:0] : 2'b00;

    // Software writes to fields
    if (wr_en)
    begin
      case (address)
        `TLB_OFS_STATUS:
        begin
          next_st.privilege_field = writedata[`TLB_ST_PRIV_LO +: 2];
          next_st.exception_level_bit = writedata[`TLB_ST_EXL];
          next_st.error_level_bit = writedata[`TLB_ST_ERL];
          next_st.user_wide_addr_bit = writedata[`TLB_ST_UX];
          next_st.supervisor_wide_addr_bit = writedata[`TLB_ST_SX];
          next_st.kernel_wide_addr_bit = writedata[`TLB_ST_KX];
          next_st.coproc_three_usable_bit = writedata[`TLB_ST_CU3];
        end
        `TLB_OFS_KEY:   next_st.address_space_tag = writedata[7:0];
        `TLB_OFS_INDEX: next_st.index = writedata[5:0];
        `TLB_OFS_VPN2:  next_st.stage.vpn2 = writedata[26:0];
        `TLB_OFS_MASK:
        begin
          next_st.stage.mask = writedata[11:0];
          next_st.stage.global_bit = writedata[12];
          next_st.stage.tag = writedata[20:13];
        end
        `TLB_OFS_LO0:
        begin
          next_st.stage.pfn0 = writedata[19:0];
          next_st.stage.v0 = writedata[20];
        end
        `TLB_OFS_LO1:
        begin
          next_st.stage.pfn1 = writedata[19:0];
          next_st.stage.v1 = writedata[20];
        end
        `TLB_OFS_IMASK: next_st.imask = writedata[1:0];
        `TLB_OFS_ISTAT: next_st.istat = st.istat & ~writedata[1:0];
        default: ;
      endcase
    end

    // Hardware sets of the level bits win over a software clear
    if (exception_take)
      next_st.exception_level_bit = 1'b1;
    if (error_take)
      next_st.error_level_bit = 1'b1;

    // Entry write; an out-of-range index is dropped
    wslot = cmd[`TLB_CMD_WRND] ? st.random : st.index;
    do_wr = (cmd[`TLB_CMD_WRND] || cmd[`TLB_CMD_WIDX]) && wslot <= LAST;
    for (int i = 0; i < ENTRIES; i++)
      if (do_wr && wslot == 6'(i))
        next_st.ent[i] = st.stage;

    // Random slot walks down each cycle and wraps
    next_st.random = (st.random == 6'h0) ? LAST : st.random - 6'h1;

    // Lookup result, registered when the compare completes
    next_st.r_valid = lookup_valid;
    next_st.r_aerr  = lookup_valid && aerr;
    next_st.r_hit   = lookup_valid && !aerr && (unmapped || any_hit);
    next_st.r_miss  = lookup_valid && !aerr && !unmapped &&
                      !any_hit;
    next_st.r_paddr = unmapped ? {3'h0, lookup_vaddr[28:0]}
                               : mapped_pa;

    // Sticky events, set beats the write-one clear
    ev = {next_st.r_aerr, next_st.r_miss};
    next_st.istat = next_st.istat | ev;

    // Read takes one wait cycle, data held in a flop
    next_st.rd_pend = read && !st.rd_pend;
    if (read && !st.rd_pend)
    begin
      case (address)
        `TLB_OFS_STATUS:
          next_st.rdata = {17'h0, wide_addr, isa_levels, mode,
                           st.coproc_three_usable_bit,
                           st.kernel_wide_addr_bit,
                           st.supervisor_wide_addr_bit,
                           st.user_wide_addr_bit,
                           st.error_level_bit,
                           st.exception_level_bit,
                           st.privilege_field};
        `TLB_OFS_KEY:    next_st.rdata = {24'h0, st.address_space_tag};
        `TLB_OFS_INDEX:  next_st.rdata = {26'h0, st.index};
        `TLB_OFS_RANDOM: next_st.rdata = {26'h0, st.random};
        `TLB_OFS_VPN2:   next_st.rdata = {5'h0, st.stage.vpn2};
        `TLB_OFS_MASK:
          next_st.rdata = {11'h0, st.stage.tag, st.stage.global_bit,
                           st.stage.mask};
        `TLB_OFS_LO0: next_st.rdata = {11'h0, st.stage.v0, st.stage.pfn0};
        `TLB_OFS_LO1: next_st.rdata = {11'h0, st.stage.v1, st.stage.pfn1};
        `TLB_OFS_ISTAT:  next_st.rdata = {30'h0, st.istat};
        `TLB_OFS_IMASK:  next_st.rdata = {30'h0, st.imask};
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Synchronous reset; entries come up invalid
    if (reset)
    begin
      next_st = '0;
      next_st.privilege_field = `TLB_RST_PRIV;
      next_st.exception_level_bit = `TLB_RST_EXL;
      next_st.error_level_bit = `TLB_RST_ERL;
      next_st.random = LAST;
    end
  end

  // Single state register
  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  // Outputs
  assign waitrequest     = read && !st.rd_pend;
  assign readdata        = st.rdata;
  assign irq             = |(st.istat & st.imask);
  assign result_valid    = st.r_valid;
  assign result_hit      = st.r_hit;
  assign result_miss     = st.r_miss;
  assign result_addr_err = st.r_aerr;
  assign result_paddr    = st.r_paddr;
endmodule
`default_nettype wire

// File: hw/tlb_pkg.sv
// Types shared by the lookup block and its bench.
// Assumes tlb_defs.svh holds the numeric constants.
package tlb_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    TLB_MODE_KERNEL = 2'b00,
    TLB_MODE_SUPER  = 2'b01,
    TLB_MODE_USER   = 2'b10
  } tlb_mode_t;
  // One entry: an even/odd page pair
  typedef struct packed {
    logic [26:0] vpn2;
    logic [11:0] mask;
    logic        global_bit;
    logic [7:0]  tag;
    logic [19:0] pfn0;
    logic        v0;
    logic [19:0] pfn1;
    logic        v1;
  } tlb_entry_t;
endpackage

// File: verification/tlb_lookup_chk.sv
// Checker for the lookup block, watching only its top-level ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_chk #(
  parameter int ENTRIES = 48
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // Lookup side
  input  wire logic               lookup_valid,
  input  wire logic [63:0]        lookup_vaddr,
  input  wire logic               result_valid,
  input  wire logic               result_hit,
  input  wire logic               result_miss,
  input  wire logic               result_addr_err,
  input  wire logic [31:0]        result_paddr,
  // Events and mode decode
  input  wire logic               exception_take,
  input  wire logic               error_take,
  input  wire tlb_pkg::tlb_mode_t mode,
  input  wire logic [3:0]         isa_levels,
  input  wire logic               wide_addr,
  input  wire logic               irq
);
  import tlb_pkg::*;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_result_next: assert property (lookup_valid |=> result_valid)
    else $error("lookup not answered next cycle");
  a_no_stray: assert property (!lookup_valid |=> !result_valid)
    else $error("result without lookup");
  a_quiet_flags: assert property (!result_valid |-> !result_hit)
    else $error("hit flag outside result");
  a_one_verdict: assert property (result_valid |->
    $onehot({result_hit, result_miss, result_addr_err}))
    else $error("result verdict not one-hot");
  // Unmapped kernel window bypasses the buffer entirely
  a_unmapped_hit: assert property (lookup_valid &&
    mode == TLB_MODE_KERNEL && (&lookup_vaddr[63:31]) && !lookup_vaddr[30]
    |=> result_hit && result_paddr == {3'b000, $past(lookup_vaddr[28:0])})
    else $error("unmapped address not passed through");
  a_event_kernel: assert property ((exception_take || error_take)
    |=> mode == TLB_MODE_KERNEL ##0 isa_levels == 4'hf)
    else $error("event did not force kernel mode");
  // Level three and width both follow the same wide bit
  a_user_levels: assert property (mode == TLB_MODE_USER |->
    isa_levels[1:0] == 2'b11 && isa_levels[2] == wide_addr)
    else $error("user level decode wrong");
  a_super_levels: assert property (mode == TLB_MODE_SUPER |->
    isa_levels[3] && isa_levels[1:0] == 2'b11 && isa_levels[2] == wide_addr)
    else $error("supervisor level decode wrong");
  a_kernel_all: assert property (mode == TLB_MODE_KERNEL |->
    isa_levels == 4'hf)
    else $error("kernel level decode wrong");
  c_hit: cover property (result_valid && result_hit);
  c_miss: cover property (result_valid && result_miss);
  c_user: cover property (mode == TLB_MODE_USER);
  c_irq: cover property (irq);
endmodule
bind tlb_lookup tlb_lookup_chk #(.ENTRIES(ENTRIES)) u_chk (.clock, .reset,
  .lookup_valid, .lookup_vaddr, .result_valid, .result_hit, .result_miss,
  .result_addr_err, .result_paddr, .exception_take, .error_take, .mode,
  .isa_levels, .wide_addr, .irq);
`default_nettype wire

// File: verification/tlb_lookup_tb.sv
// Self-checking bench for the lookup block over Avalon-MM.
// Assumes tlb_defs.svh offsets and the pipeline model beside it.
`include "tlb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_tb;
  import tlb_pkg::*;
  // ------------------------------------------------------------
  // Signals, instances, tasks
  // ------------------------------------------------------------
  logic clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd;
  wire  logic  waitrequest, irq, lookup_valid, exception_take, error_take;
  wire  logic  result_valid, result_hit, result_miss, result_addr_err;
  wire  logic  wide_addr, interrupts_blocked;
  wire  logic [63:0] lookup_vaddr;
  wire  logic [31:0] result_paddr;
  wire  logic [3:0]  isa_levels;
  wire  tlb_mode_t   mode;
  int err_count = 0;
  int n_tests = 0;
  // Status in, then mode, levels, width, blocked
  logic [15:0] rows [8] = '{16'h028C, 16'h92BE, 16'h82AC, 16'h016C,
                            16'h217E, 16'h003C, 16'h463F, 16'h093D};
  always #12.5 clock = ~clock;
  tlb_lookup #(.ENTRIES(48)) dut (.clock, .reset, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .irq, .lookup_valid, .lookup_vaddr,
    .result_valid, .result_hit, .result_miss, .result_addr_err,
    .result_paddr, .exception_take, .error_take, .mode, .isa_levels,
    .wide_addr, .interrupts_blocked);
  tlb_pipe_model pip (.clock, .lookup_valid, .lookup_vaddr, .exception_take,
    .error_take, .result_valid, .result_hit, .result_miss,
    .result_addr_err, .result_paddr);
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Held request until waitrequest is seen low; bounded wait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clock);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 16)
    begin
      chk(1'b0, "bus timeout");
      results;
    end
  endtask
  // Stage and commit one entry, by index or by random slot
  task entry(input logic rnd, input logic [31:0] v, m, l0, l1);
    bus(1'b1, `TLB_OFS_VPN2, v);
    bus(1'b1, `TLB_OFS_MASK, m);
    bus(1'b1, `TLB_OFS_LO0, l0);
    bus(1'b1, `TLB_OFS_LO1, l1);
    bus(1'b1, `TLB_OFS_CMD, rnd ? 32'h0000_0002 : 32'h0000_0001);
  endtask
  task look(input logic [63:0] va, input logic h, input logic [31:0] pa);
    pip.issue(va);
    chk(pip.got_valid === 1'b1 && pip.got_hit === h, "verdict");
    chk(pip.got_miss === !h && pip.got_aerr === 1'b0, "miss flag");
    chk(h === 1'b0 || pip.got_paddr === pa, "physical address");
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(mode === TLB_MODE_KERNEL && interrupts_blocked === 1'b1, "reset");
    chk(irq === 1'b0 && result_valid === 1'b0, "reset outputs");
    foreach (rows[i])
    begin
      bus(1'b1, `TLB_OFS_STATUS, 32'(rows[i][15:8]));
      @(negedge clock);
      chk(mode === rows[i][7:6] && isa_levels === rows[i][5:2], "mode");
      chk(wide_addr === rows[i][1], "width");
      chk(interrupts_blocked === rows[i][0], "blocked");
    end
    bus(1'b0, 8'h3C, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "unmapped offset");
    // Exception from user keeps the privilege field
    bus(1'b1, `TLB_OFS_STATUS, 32'h0000_0002);
    pip.pulse(1'b0);
    @(negedge clock);
    chk(mode === TLB_MODE_KERNEL && interrupts_blocked === 1'b1, "exc");
    bus(1'b0, `TLB_OFS_STATUS, 32'h0000_0000);
    chk(rd[2:0] === 3'b110, "privilege kept");
    bus(1'b1, `TLB_OFS_STATUS, 32'h0000_0001);
    @(negedge clock);
    chk(mode === TLB_MODE_SUPER, "return to field mode");
    pip.pulse(1'b1);
    @(negedge clock);
    chk(mode === TLB_MODE_KERNEL && interrupts_blocked === 1'b1, "err");
    // Translation in kernel narrow mode
    bus(1'b1, `TLB_OFS_STATUS, 32'h0000_0000);
    bus(1'b1, `TLB_OFS_KEY, 32'h0000_0005);
    bus(1'b1, `TLB_OFS_INDEX, 32'h0000_0000);
    entry(1'b0, 32'h0000_0201, 32'h0000_A000, 32'h0011_2345, 32'h0016_789A);
    look(64'h0000_0000_0040_2ABC, 1'b1, 32'h1234_5ABC);
    look(64'h0000_0000_0040_3ABC, 1'b1, 32'h6789_AABC);
    bus(1'b1, `TLB_OFS_KEY, 32'h0000_0006);
    look(64'h0000_0000_0040_2ABC, 1'b0, 32'h0000_0000);
    @(negedge clock);
    chk(irq === 1'b0, "masked miss");
    bus(1'b1, `TLB_OFS_IMASK, 32'h0000_0001);
    @(negedge clock);
    chk(irq === 1'b1, "miss interrupt");
    bus(1'b1, `TLB_OFS_ISTAT, 32'h0000_0001);
    @(negedge clock);
    chk(irq === 1'b0, "interrupt cleared");
    // Global entry in a random slot, then a 16 MB page in the last slot
    entry(1'b1, 32'h0000_0201, 32'h0000_1000, 32'h0010_ABCD, 32'h0010_0000);
    look(64'h0000_0000_0040_2ABC, 1'b1, 32'h0ABC_DABC);
    bus(1'b1, `TLB_OFS_INDEX, 32'h0000_002F);
    entry(1'b0, 32'h0000_0C00, 32'h0000_1FFF, 32'h0010_0000, 32'h0015_5000);
    look(64'h0000_0000_0180_0123, 1'b1, 32'h5580_0123);
    look(64'hFFFF_FFFF_A123_4567, 1'b1, 32'h0123_4567);
    // Narrow kernel refuses a high address; wide kernel looks it up
    pip.issue(64'h0000_0001_0000_0000);
    chk(pip.got_aerr === 1'b1 && pip.got_hit === 1'b0, "narrow");
    bus(1'b1, `TLB_OFS_STATUS, 32'h0000_0040);
    look(64'h0000_0001_0000_0000, 1'b0, 32'h0000_0000);
    bus(1'b0, `TLB_OFS_RANDOM, 32'h0000_0000);
    chk(rd <= 32'h0000_002F, "random slot range");
    // Mid-run reset drops every entry and the pending events
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(mode === TLB_MODE_KERNEL && irq === 1'b0, "reset again");
    look(64'h0000_0000_0180_0123, 1'b0, 32'h0000_0000);
    results;
  end
endmodule
`default_nettype wire

// File: verification/tlb_pipe_model.sv
// Pipeline model: presents addresses and raises exception events.
// Assumes results come one cycle after the edge taking a lookup.
`timescale 1ns/1ps
`default_nettype none
module tlb_pipe_model (
  // Clock
  input  wire logic        clock,
  // Requests
  output logic             lookup_valid,
  output logic [63:0]      lookup_vaddr,
  output logic             exception_take,
  output logic             error_take,
  // Results
  input  wire logic        result_valid,
  input  wire logic        result_hit,
  input  wire logic        result_miss,
  input  wire logic        result_addr_err,
  input  wire logic [31:0] result_paddr
);
  // ------------------------------------------------------------
  // Request tasks
  // ------------------------------------------------------------
  logic        got_valid;
  logic        got_hit;
  logic        got_miss;
  logic        got_aerr;
  logic [31:0] got_paddr;
  initial lookup_valid = 1'b0;
  initial lookup_vaddr = '0;
  initial exception_take = 1'b0;
  initial error_take = 1'b0;
  // One lookup; address inverted afterwards so nothing stale lingers
  task issue(input logic [63:0] va);
    @(posedge clock);
    lookup_valid <= 1'b1;
    lookup_vaddr <= va;
    @(posedge clock);
    lookup_valid <= 1'b0;
    lookup_vaddr <= ~va;
    @(posedge clock);
    got_valid = result_valid;
    got_hit = result_hit;
    got_miss = result_miss;
    got_aerr = result_addr_err;
    got_paddr = result_paddr;
  endtask
  // One-cycle event pulse
  task pulse(input logic err);
    @(posedge clock);
    exception_take <= ~err;
    error_take <= err;
    @(posedge clock);
    exception_take <= 1'b0;
    error_take <= 1'b0;
  endtask
endmodule
`default_nettype wire
